/* logic/bcd_pkg.sv */
// Notes on behaviour
// - start rises while negative/positive sequence ratio is above the limit, if qualified.
// - start only while positive sequence current is 6.67% to 100% of rated.
// - start and trip held low while disabled or while the block input is high.
// - trip only after the delay elapsed with start present and tripping allowed.
// - start-only setting keeps start working but never trips; resets to false.
// - ratio in percent compared with a 10 to 90 limit, step 1, default 50.
// - delay 100 to 60000 ms in 1 ms steps, default 1000, from fault appearance.
// - two outputs, general start and general trip, each reported on and off.
`default_nettype none

package bcd_pkg;
   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int MAG_W  = 16;
   localparam int LIM_W  = 7;
   localparam int DLY_W  = 16;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int EV_W   = 4;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] CTRL_OFS     = 5'h00;
   localparam logic [ADDR_W-1:0] LIMIT_OFS    = 5'h04;
   localparam logic [ADDR_W-1:0] DELAY_OFS    = 5'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS   = 5'h0c;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 5'h10;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h14;

   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_SO_BIT   = 1;
   localparam int STAT_ST_BIT   = 0;
   localparam int STAT_TR_BIT   = 1;
   localparam int STAT_OVR_BIT  = 2;
   localparam int STAT_WIN_BIT  = 3;
   localparam int EV_ST_ON_BIT  = 0;
   localparam int EV_ST_OFF_BIT = 1;
   localparam int EV_TR_ON_BIT  = 2;
   localparam int EV_TR_OFF_BIT = 3;

   // ****************************************************************
   // settings ranges and reset values
   // ****************************************************************
   localparam logic [LIM_W-1:0] LIMIT_MIN = 7'h0a;
   localparam logic [LIM_W-1:0] LIMIT_MAX = 7'h5a;
   localparam logic [LIM_W-1:0] LIMIT_RST = 7'h32;
   localparam logic [DLY_W-1:0] DELAY_MIN = 16'h0064;
   localparam logic [DLY_W-1:0] DELAY_MAX = 16'hea60;
   localparam logic [DLY_W-1:0] DELAY_RST = 16'h03e8;
   localparam logic [EV_W-1:0]  MASK_RST  = 4'h0;

   localparam logic [LIM_W-1:0] PCT_FULL    = 7'h64;
   // 6.67 % of rated is rated / 15
   localparam logic [LIM_W-1:0] WIN_LOW_DIV = 7'h0f;
   localparam logic [MAG_W-1:0] RATED_DEF   = 16'h1000;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int MS_NS          = 1000000;
   localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int TICK_W         = 17;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_TIMING  = 2'b01,
      ST_TRIPPED = 2'b10
   } delay_state_t;
endpackage : bcd_pkg

`default_nettype wire

/* logic/ratio_if.sv */
`default_nettype none

interface ratio_if;
   import bcd_pkg::*;
   logic [MAG_W-1:0] pos_mag;
   logic [MAG_W-1:0] neg_mag;
   logic [LIM_W-1:0] limit;
   logic             ratio_over;
   logic             window_ok;

   modport top (output pos_mag, output neg_mag, output limit,
                input ratio_over, input window_ok);
   modport cmp (input pos_mag, input neg_mag, input limit,
                output ratio_over, output window_ok);
endinterface : ratio_if

`default_nettype wire

/* logic/ratio_compare.sv */
`default_nettype none

module ratio_compare
#(
   parameter logic [bcd_pkg::MAG_W-1:0] RATED = bcd_pkg::RATED_DEF
)
(
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   ratio_if.cmp      rif
);
   import bcd_pkg::*;

   localparam int PW = MAG_W + LIM_W;

   logic          over_r;
   logic          over_nxt;
   logic          win_r;
   logic          win_nxt;
   logic [PW-1:0] neg_pct;
   logic [PW-1:0] lim_prod;

   // ****************************************************************
   // cross multiplication avoids a divider
   // ****************************************************************
   always_comb
   begin
      neg_pct  = PW'(rif.neg_mag) * PW'(PCT_FULL);
      lim_prod = PW'(rif.pos_mag) * PW'(rif.limit);
      over_nxt = (neg_pct > lim_prod) && (rif.pos_mag != '0);
      win_nxt  = (PW'(rif.pos_mag) * PW'(WIN_LOW_DIV) > PW'(RATED))
                 && (rif.pos_mag < RATED);
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         over_r <= 1'b0;
         win_r  <= 1'b0;
      end
      else
      begin
         over_r <= over_nxt;
         win_r  <= win_nxt;
      end
   end

   assign rif.ratio_over = over_r;
   assign rif.window_ok  = win_r;
endmodule : ratio_compare

`default_nettype wire

/* logic/broken_conductor_detector.sv */
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`default_nettype none

module broken_conductor_detector
#(
   parameter int                         TICK_CYCLES = bcd_pkg::MS_TICK_CYCLES,
   parameter logic [bcd_pkg::MAG_W-1:0]  RATED       = bcd_pkg::RATED_DEF
)
(
   input  wire logic                         core_clk_in,
   input  wire logic                         rst_in,
   input  wire logic [bcd_pkg::MAG_W-1:0]    pos_seq_magnitude_in,
   input  wire logic [bcd_pkg::MAG_W-1:0]    neg_seq_magnitude_in,
   input  wire logic                         block_input_in,
   input  wire logic [bcd_pkg::ADDR_W-1:0]   avs_address_in,
   input  wire logic                         avs_read_in,
   input  wire logic                         avs_write_in,
   input  wire logic [bcd_pkg::DATA_W-1:0]   avs_writedata_in,
   input  wire logic [3:0]                   avs_byteenable_in,
   output logic      [bcd_pkg::DATA_W-1:0]   avs_readdata_out,
   output logic                              avs_waitrequest_out,
   output logic                              general_start_out,
   output logic                              general_trip_out,
   output logic                              irq_out
);
   import bcd_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic                enable_r;
   logic                enable_nxt;
   logic                start_only_r;
   logic                start_only_nxt;
   logic [LIM_W-1:0]    limit_r;
   logic [LIM_W-1:0]    limit_nxt;
   logic [DLY_W-1:0]    delay_r;
   logic [DLY_W-1:0]    delay_nxt;
   logic [EV_W-1:0]     irq_stat_r;
   logic [EV_W-1:0]     irq_stat_nxt;
   logic [EV_W-1:0]     irq_mask_r;
   logic [EV_W-1:0]     irq_mask_nxt;
   logic                ack_r;
   logic                ack_nxt;
   logic [DATA_W-1:0]   rdata_r;
   logic [DATA_W-1:0]   rdata_nxt;
   delay_state_t        state_r;
   delay_state_t        state_nxt;
   logic [DLY_W-1:0]    ms_cnt_r;
   logic [DLY_W-1:0]    ms_cnt_nxt;
   logic [TICK_W-1:0]   tick_cnt_r;
   logic [TICK_W-1:0]   tick_cnt_nxt;
   logic                start_r;
   logic                start_nxt;
   logic                trip_r;
   logic                trip_nxt;
   logic                start_cond;
   logic                ms_tick;
   logic                wr_en;
   logic [EV_W-1:0]     events;
   logic [DATA_W-1:0]   wmask;
   logic [DATA_W-1:0]   ctrl_wr;
   logic [DATA_W-1:0]   lim_wr;
   logic [DATA_W-1:0]   dly_wr;
   logic [DATA_W-1:0]   mask_wr;

   ratio_if rif ();

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [DATA_W-1:0] merge_bytes
   (
      input logic [DATA_W-1:0] old_val,
      input logic [DATA_W-1:0] new_val,
      input logic [DATA_W-1:0] mask
   );
      merge_bytes = (old_val & ~mask) | (new_val & mask);
   endfunction : merge_bytes

   function automatic logic [DATA_W-1:0] bytes_to_mask
   (
      input logic [3:0] be
   );
      bytes_to_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : bytes_to_mask

   // ****************************************************************
   // magnitude comparison
   // ****************************************************************
   assign rif.pos_mag = pos_seq_magnitude_in;
   assign rif.neg_mag = neg_seq_magnitude_in;
   assign rif.limit   = limit_r;

   ratio_compare
   #(
      .RATED (RATED)
   )
   u_cmp
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .rif         (rif)
   );

   // ****************************************************************
   // start qualification
   // ****************************************************************
   // block input comes from same-clock user logic, so it is not synchronised
   assign start_cond = enable_r && !block_input_in
                       && rif.ratio_over && rif.window_ok;

   // ****************************************************************
   // delay timer
   // ****************************************************************
   // the millisecond divider restarts with each start so the delay is
   // not shortened by a partly elapsed tick
   assign ms_tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

   always_comb
   begin
      state_nxt    = state_r;
      ms_cnt_nxt   = ms_cnt_r;
      tick_cnt_nxt = ms_tick ? '0 : tick_cnt_r + 1'b1;
      unique case (state_r)
         ST_IDLE:
         begin
            ms_cnt_nxt   = '0;
            tick_cnt_nxt = '0;
            if (start_cond)
               state_nxt = ST_TIMING;
         end
         ST_TIMING:
         begin
            if (!start_cond)
            begin
               state_nxt  = ST_IDLE;
               ms_cnt_nxt = '0;
            end
            else if (ms_cnt_r >= delay_r && !start_only_r)
               state_nxt = ST_TRIPPED;
            else if (ms_tick && ms_cnt_r < delay_r)
               ms_cnt_nxt = ms_cnt_r + 1'b1;
         end
         ST_TRIPPED:
         begin
            if (!start_cond)
            begin
               state_nxt  = ST_IDLE;
               ms_cnt_nxt = '0;
            end
            else if (start_only_r)
               state_nxt = ST_TIMING;
         end
         default:
         begin
            state_nxt  = ST_IDLE;
            ms_cnt_nxt = '0;
         end
      endcase
      start_nxt = start_cond;
      trip_nxt  = (state_nxt == ST_TRIPPED);
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state_r    <= ST_IDLE;
         ms_cnt_r   <= '0;
         tick_cnt_r <= '0;
         start_r    <= 1'b0;
         trip_r     <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         ms_cnt_r   <= ms_cnt_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         start_r    <= start_nxt;
         trip_r     <= trip_nxt;
      end
   end

   assign general_start_out = start_r;
   assign general_trip_out  = trip_r;

   // ****************************************************************
   // on and off events
   // ****************************************************************
   always_comb
   begin
      events                = '0;
      events[EV_ST_ON_BIT]  = start_nxt && !start_r;
      events[EV_ST_OFF_BIT] = !start_nxt && start_r;
      events[EV_TR_ON_BIT]  = trip_nxt && !trip_r;
      events[EV_TR_OFF_BIT] = !trip_nxt && trip_r;
   end

   // ****************************************************************
   // avalon slave and settings
   // ****************************************************************
   // every access waits one cycle; write lands at the edge that ends it
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;
   assign avs_readdata_out    = rdata_r;
   assign wr_en               = avs_write_in && ack_r;
   assign irq_out             = |(irq_stat_r & irq_mask_r);

   always_comb
   begin
      wmask          = bytes_to_mask(avs_byteenable_in);
      ctrl_wr        = merge_bytes({30'h0, start_only_r, enable_r},
                                   avs_writedata_in, wmask);
      lim_wr         = merge_bytes({25'h0, limit_r}, avs_writedata_in, wmask);
      dly_wr         = merge_bytes({16'h0, delay_r}, avs_writedata_in, wmask);
      mask_wr        = merge_bytes({28'h0, irq_mask_r}, avs_writedata_in,
                                   wmask);
      enable_nxt     = enable_r;
      start_only_nxt = start_only_r;
      limit_nxt      = limit_r;
      delay_nxt      = delay_r;
      irq_mask_nxt   = irq_mask_r;
      irq_stat_nxt   = irq_stat_r;
      ack_nxt        = (avs_read_in || avs_write_in) && !ack_r;
      rdata_nxt      = rdata_r;
      if (wr_en)
      begin
         unique case (avs_address_in)
            CTRL_OFS:
            begin
               enable_nxt     = ctrl_wr[CTRL_EN_BIT];
               start_only_nxt = ctrl_wr[CTRL_SO_BIT];
            end
            LIMIT_OFS:
            begin
               // out-of-range writes clamp to the nearest legal setting
               if (lim_wr > DATA_W'(LIMIT_MAX))
                  limit_nxt = LIMIT_MAX;
               else if (lim_wr < DATA_W'(LIMIT_MIN))
                  limit_nxt = LIMIT_MIN;
               else
                  limit_nxt = lim_wr[LIM_W-1:0];
            end
            DELAY_OFS:
            begin
               if (dly_wr > DATA_W'(DELAY_MAX))
                  delay_nxt = DELAY_MAX;
               else if (dly_wr < DATA_W'(DELAY_MIN))
                  delay_nxt = DELAY_MIN;
               else
                  delay_nxt = dly_wr[DLY_W-1:0];
            end
            IRQ_STAT_OFS:
               irq_stat_nxt = irq_stat_r
                              & ~(avs_writedata_in[EV_W-1:0] & wmask[EV_W-1:0]);
            IRQ_MASK_OFS:
               irq_mask_nxt = mask_wr[EV_W-1:0];
            default:
               irq_mask_nxt = irq_mask_r;
         endcase
      end
      // a new event wins over a clear in the same cycle
      irq_stat_nxt = irq_stat_nxt | events;
      if (avs_read_in && !ack_r)
      begin
         unique case (avs_address_in)
            CTRL_OFS:     rdata_nxt = {30'h0, start_only_r, enable_r};
            LIMIT_OFS:    rdata_nxt = {25'h0, limit_r};
            DELAY_OFS:    rdata_nxt = {16'h0, delay_r};
            STATUS_OFS:   rdata_nxt = {28'h0, rif.window_ok, rif.ratio_over,
                                       trip_r, start_r};
            IRQ_STAT_OFS: rdata_nxt = {28'h0, irq_stat_r};
            IRQ_MASK_OFS: rdata_nxt = {28'h0, irq_mask_r};
            default:      rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         enable_r     <= 1'b0;
         start_only_r <= 1'b0;
         limit_r      <= LIMIT_RST;
         delay_r      <= DELAY_RST;
         irq_stat_r   <= '0;
         irq_mask_r   <= MASK_RST;
         ack_r        <= 1'b0;
         rdata_r      <= '0;
      end
      else
      begin
         enable_r     <= enable_nxt;
         start_only_r <= start_only_nxt;
         limit_r      <= limit_nxt;
         delay_r      <= delay_nxt;
         irq_stat_r   <= irq_stat_nxt;
         irq_mask_r   <= irq_mask_nxt;
         ack_r        <= ack_nxt;
         rdata_r      <= rdata_nxt;
      end
   end
endmodule : broken_conductor_detector

`default_nettype wire

/* test/seq_source.sv */
`default_nettype none
// ****************************************************************
// upstream sequence magnitude source; holds stale values until told
// ****************************************************************
module seq_source
(
   input  wire logic                      core_clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      upd_in,
   input  wire logic [bcd_pkg::MAG_W-1:0] pos_set_in,
   input  wire logic [bcd_pkg::MAG_W-1:0] neg_set_in,
   output logic      [bcd_pkg::MAG_W-1:0] pos_out,
   output logic      [bcd_pkg::MAG_W-1:0] neg_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import bcd_pkg::*;
   // only the two rms magnitudes leave this stage
   always_ff @(posedge core_clk_in)
      if (rst_in)
      begin
         pos_out <= '0;
         neg_out <= '0;
      end
      else if (upd_in)
      begin
         pos_out <= pos_set_in;
         neg_out <= neg_set_in;
      end
endmodule : seq_source
`default_nettype wire

/* test/bcd_sva.sv */
`default_nettype none
// ****************************************************************
// port checker
// ****************************************************************
module bcd_sva
#(
   parameter int                        TICK_CYCLES = 10,
   parameter logic [bcd_pkg::MAG_W-1:0] RATED       = 16'h1000
)
(
   input wire logic                      core_clk_in,
   input wire logic                      rst_in,
   input wire logic [bcd_pkg::MAG_W-1:0] pos_seq_magnitude_in,
   input wire logic [bcd_pkg::MAG_W-1:0] neg_seq_magnitude_in,
   input wire logic                      block_input_in,
   input wire logic                      avs_read_in,
   input wire logic                      avs_write_in,
   input wire logic                      avs_waitrequest_out,
   input wire logic                      general_start_out,
   input wire logic                      general_trip_out,
   input wire logic                      irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import bcd_pkg::*;
   // a few cycles of slack for the pipeline in front of the timer
   localparam int MIN_T = 100 * TICK_CYCLES - 4;
   logic [31:0] st_cnt_r;
   wire  [31:0] pos_w = {16'h0, pos_seq_magnitude_in};
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge core_clk_in)
      if (rst_in || !general_start_out)
         st_cnt_r <= '0;
      else
         st_cnt_r <= st_cnt_r + 32'h1;
   sequence s_req_new;
      (avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in);
   endsequence
   sequence s_ack;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   property p_bus;
      s_req_new |-> s_ack;
   endproperty
   property p_rst;
      $fell(rst_in) |-> (!general_start_out && !general_trip_out
                         && !irq_out)[*3];
   endproperty
   property p_block;
      block_input_in[*2] |-> !general_start_out && !general_trip_out;
   endproperty
   property p_trip_start;
      general_trip_out |-> general_start_out;
   endproperty
   property p_trip_time;
      $rose(general_trip_out) |-> st_cnt_r >= MIN_T;
   endproperty
   property p_drop;
      $fell(general_start_out) |-> (!general_trip_out)[*3];
   endproperty
   property p_neg0;
      (neg_seq_magnitude_in == 16'h0)[*3] |-> !general_start_out;
   endproperty
   property p_win_hi;
      (pos_seq_magnitude_in >= RATED)[*3] |-> !general_start_out;
   endproperty
   property p_win_lo;
      (pos_w * 32'h0f <= {16'h0, RATED})[*3] |-> !general_start_out;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer late");
   a_rst: assert property (p_rst) else $error("output after reset");
   a_block: assert property (p_block) else $error("blocked out");
   a_trip_start: assert property (p_trip_start)
      else $error("trip without start");
   a_trip_time: assert property (p_trip_time)
      else $error("trip too early");
   a_drop: assert property (p_drop) else $error("trip after drop");
   a_neg0: assert property (p_neg0) else $error("start no ratio");
   a_win_hi: assert property (p_win_hi) else $error("start high");
   a_win_lo: assert property (p_win_lo) else $error("start low");
endmodule : bcd_sva
bind broken_conductor_detector bcd_sva #(.TICK_CYCLES(TICK_CYCLES),
   .RATED(RATED)) bcd_sva_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .pos_seq_magnitude_in(pos_seq_magnitude_in),
   .neg_seq_magnitude_in(neg_seq_magnitude_in),
   .block_input_in(block_input_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .general_start_out(general_start_out),
   .general_trip_out(general_trip_out), .irq_out(irq_out));
`default_nettype wire

/* test/broken_conductor_detector_test.sv */
`default_nettype none
// ****************************************************************
// self-checking bench
// ****************************************************************
module broken_conductor_detector_test;
   timeunit 1ns;
   timeprecision 1ns;
   import bcd_pkg::*;
   localparam int TK = 10;
   logic              clk, rst, upd, blk, rd, wr, wq, st, tr, irq;
   logic [MAG_W-1:0]  pset, nset, pos, neg;
   logic [ADDR_W-1:0] adr;
   logic [31:0]       wd, rdv, q, seed;
   logic [3:0]        be;
   int                n_mismatch, samples_checked, n;
   int                cyc = 0;
   logic [4:0]  ra [7] = '{CTRL_OFS, LIMIT_OFS, DELAY_OFS, STATUS_OFS,
                          IRQ_STAT_OFS, IRQ_MASK_OFS, 5'h18};
   logic [31:0] rv [7] = '{32'h0, 32'h32, 32'h3e8, 32'h0, 32'h0, 32'h0,
                          32'h0};
   logic [31:0] cw [6] = '{32'h05, 32'h7f, 32'h32, 32'h0a, 32'hfde8, 32'h64};
   logic [31:0] ce [6] = '{32'h0a, 32'h5a, 32'h32, 32'h64, 32'hea60, 32'h64};
   logic [15:0] cp [7] = '{16'h1000, 16'h0fff, 16'h0111, 16'h0112, 16'h03e8,
                          16'h03e8, 16'h07d0};
   logic [15:0] cn [7] = '{16'h0fa0, 16'h0fa0, 16'h0111, 16'h0112, 16'h01f4,
                          16'h01f5, 16'h0000};
   seq_source seq_source_i (.core_clk_in(clk), .rst_in(rst), .upd_in(upd),
      .pos_set_in(pset), .neg_set_in(nset), .pos_out(pos), .neg_out(neg));
   broken_conductor_detector #(.TICK_CYCLES(TK), .RATED(RATED_DEF))
      broken_conductor_detector_i (.core_clk_in(clk), .rst_in(rst),
      .pos_seq_magnitude_in(pos), .neg_seq_magnitude_in(neg),
      .block_input_in(blk), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdv), .avs_waitrequest_out(wq),
      .general_start_out(st), .general_trip_out(tr), .irq_out(irq));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic exp_st(input logic [15:0] p, input logic [15:0] m);
      return (32'(p) * 32'h0f > 32'(RATED_DEF)) && (p < RATED_DEF)
             && (32'(m) * 32'h64 > 32'(p) * 32'h32);
   endfunction : exp_st
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : chk
   task automatic end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   // request held until waitrequest is sampled low, then released
   task automatic xfer(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      while (wq !== 1'b0 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 20)
         n_mismatch++;
      q = rdv;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : xfer
   task automatic put(input logic [15:0] p, input logic [15:0] m);
      @(posedge clk);
      pset <= p;
      nset <= m;
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : put
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial
   begin
      rst = 1'b1;
      {pset, nset, upd, blk, rd, wr, adr, wd} = '0;
      be = 4'hf;
      seed = 32'h045b;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         xfer(1'b0, ra[i], 32'h0);
         chk(q, rv[i]);
      end
      for (int i = 0; i < 6; i++)
      begin
         xfer(1'b1, (i < 3) ? LIMIT_OFS : DELAY_OFS, cw[i]);
         xfer(1'b0, (i < 3) ? LIMIT_OFS : DELAY_OFS, 32'h0);
         chk(q, ce[i]);
      end
      be <= 4'h0;
      xfer(1'b1, LIMIT_OFS, 32'h20);
      be <= 4'hf;
      xfer(1'b0, LIMIT_OFS, 32'h0);
      chk(q, 32'h32);
      xfer(1'b1, IRQ_MASK_OFS, 32'hf);
      xfer(1'b1, CTRL_OFS, 32'h1);
      for (int i = 0; i < 37; i++)
      begin
         seed = xs(seed);
         if (i < 7)
            put(cp[i], cn[i]);
         else
            put({3'h0, seed[12:0]}, {3'h0, seed[28:16]});
         chk(st, exp_st(pset, nset));
      end
      put(16'h03e8, 16'h0258);
      chk(st, 32'h1);
      blk <= 1'b1;
      repeat (2) @(posedge clk);
      chk({st, tr}, 32'h0);
      blk <= 1'b0;
      xfer(1'b1, CTRL_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk(st, 32'h0);
      xfer(1'b1, IRQ_STAT_OFS, 32'hf);
      @(posedge clk);
      chk(irq, 32'h0);
      xfer(1'b1, CTRL_OFS, 32'h1);
      repeat (500) @(posedge clk);
      chk(tr, 32'h0);
      put(16'h03e8, 16'h0);
      chk({st, tr}, 32'h0);
      put(16'h03e8, 16'h0258);
      n = 0;
      while (tr !== 1'b1 && n < 1200)
      begin
         @(posedge clk);
         n++;
      end
      chk(n >= 990 && n <= 1008, 32'h1);
      chk(irq, 32'h1);
      xfer(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(q, 32'h7);
      put(16'h03e8, 16'h0);
      chk({st, tr}, 32'h0);
      xfer(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(q, 32'hf);
      xfer(1'b1, IRQ_STAT_OFS, 32'hf);
      xfer(1'b1, IRQ_MASK_OFS, 32'h0);
      put(16'h03e8, 16'h0258);
      chk(irq, 32'h0);
      xfer(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(q, 32'h1);
      xfer(1'b1, IRQ_MASK_OFS, 32'hf);
      @(posedge clk);
      chk(irq, 32'h1);
      xfer(1'b1, CTRL_OFS, 32'h3);
      repeat (1100) @(posedge clk);
      chk({st, tr}, 32'h2);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({st, tr, irq}, 32'h0);
      xfer(1'b0, CTRL_OFS, 32'h0);
      chk(q, 32'h0);
      end_of_test();
   end
endmodule : broken_conductor_detector_test
`default_nettype wire
